// File: rtl/dex_exec.sv
// Purpose: executes the decrement and decrement-skip-if-zero opcodes
// Assumes: classic Wishbone slave, one clock, synchronous reset
// Notes:   data memory, working register and flags are held here
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "dex_regs.svh"
module dex_exec #(
  parameter int MEM_DEPTH = `DEX_MEM_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             busy_o,
  output logic             skip_o
);
  // the 8-bit address field reaches exactly 256 bytes
  if (MEM_DEPTH != `DEX_MEM_DEPTH) begin : g_chk
    $error("dex_exec: MEM_DEPTH must be 256");
  end

  dex_alu_if alu_bus ();
  dex_alu u_alu (
    .bus (alu_bus)
  );

  logic [7:0]          mem_reg [MEM_DEPTH];
  dex_pkg::dex_state_t state_reg;
  dex_pkg::dex_state_t state_next;
  logic [15:0]         opc_reg;
  logic [7:0]          work_reg;
  dex_pkg::dex_flags_t flags_reg;
  logic                is_dec_reg;
  logic                is_dsz_reg;
  logic                dest_reg;
  logic [7:0]          addr_reg;
  logic [7:0]          operand_reg;
  logic [7:0]          result_reg;
  dex_pkg::dex_flags_t calc_reg;
  logic                skip_reg;
  logic                other_reg;
  logic                req;
  logic                wr_ok;
  logic                sel_lo;
  logic                hit_mem;
  logic [7:0]          mem_idx;

  assign alu_bus.opcode  = opc_reg;
  assign alu_bus.operand = operand_reg;

  // a request is taken once; ack drops in the cycle after it was given
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // software writes to core state are ignored while an opcode runs
  assign wr_ok   = req && wb_we_i && (state_reg == dex_pkg::DEX_IDLE);
  assign sel_lo  = wb_sel_i[0];
  assign hit_mem = wb_adr_i[`DEX_ADR_HI:`DEX_ADR_MID] == `DEX_MEM_SEL;
  assign mem_idx = wb_adr_i[`DEX_ADR_WORD_HI:`DEX_ADR_WORD_LO];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dex_pkg::DEX_IDLE: begin
        if (wr_ok && sel_lo && wb_adr_i == `DEX_ADR_INSTR) begin
          state_next = dex_pkg::DEX_Q1;
        end
      end
      dex_pkg::DEX_Q1: state_next = dex_pkg::DEX_Q2;
      dex_pkg::DEX_Q2: state_next = dex_pkg::DEX_Q3;
      dex_pkg::DEX_Q3: state_next = dex_pkg::DEX_Q4;
      dex_pkg::DEX_Q4: begin
        if (skip_reg) begin
          state_next = dex_pkg::DEX_N1;
        end else begin
          state_next = dex_pkg::DEX_IDLE;
        end
      end
      dex_pkg::DEX_N1: state_next = dex_pkg::DEX_N2;
      dex_pkg::DEX_N2: state_next = dex_pkg::DEX_N3;
      dex_pkg::DEX_N3: state_next = dex_pkg::DEX_N4;
      dex_pkg::DEX_N4: state_next = dex_pkg::DEX_IDLE;
      default:         state_next = dex_pkg::DEX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= dex_pkg::DEX_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // opcode register, loaded by software; bytes 0 and 1 of the word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opc_reg <= `DEX_OPC_RESET;
    end else if (wr_ok && wb_adr_i == `DEX_ADR_INSTR) begin
      if (wb_sel_i[0]) begin
        opc_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        opc_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // phase one: latch decode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      is_dec_reg <= 1'b0;
      is_dsz_reg <= 1'b0;
      dest_reg   <= 1'b0;
      addr_reg   <= `DEX_BYTE_ZERO;
      other_reg  <= 1'b0;
    end else if (state_reg == dex_pkg::DEX_Q1) begin
      is_dec_reg <= alu_bus.is_dec;
      is_dsz_reg <= alu_bus.is_dsz;
      dest_reg   <= alu_bus.dest;
      addr_reg   <= alu_bus.addr;
      other_reg  <= !(alu_bus.is_dec || alu_bus.is_dsz);
    end
  end

  // phase two: read source; phase three: compute and decide skip
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      operand_reg <= `DEX_BYTE_ZERO;
      result_reg  <= `DEX_BYTE_ZERO;
      calc_reg    <= '0;
      skip_reg    <= 1'b0;
    end else if (state_reg == dex_pkg::DEX_Q2) begin
      operand_reg <= mem_reg[addr_reg];
      skip_reg    <= 1'b0;
    end else if (state_reg == dex_pkg::DEX_Q3) begin
      result_reg <= alu_bus.result;
      calc_reg   <= alu_bus.flags;
      skip_reg   <= is_dsz_reg && alu_bus.flags.zero;
    end
  end

  // phase four: working register destination
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      work_reg <= `DEX_BYTE_ZERO;
    end else if (state_reg == dex_pkg::DEX_Q4) begin
      if ((is_dec_reg || is_dsz_reg) && !dest_reg) begin
        work_reg <= result_reg;
      end
    end else if (wr_ok && sel_lo && wb_adr_i == `DEX_ADR_WORK) begin
      work_reg <= wb_dat_i[7:0];
    end
  end

  // only the plain decrement touches the four arithmetic flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= '0;
    end else if (state_reg == dex_pkg::DEX_Q4) begin
      if (is_dec_reg) begin
        flags_reg <= calc_reg;
      end
      // the skip variant falls through and keeps the flags
    end else if (wr_ok && sel_lo && wb_adr_i == `DEX_ADR_STATUS) begin
      flags_reg.carry  <= wb_dat_i[`DEX_ST_CARRY];
      flags_reg.dcarry <= wb_dat_i[`DEX_ST_DCARRY];
      flags_reg.zero   <= wb_dat_i[`DEX_ST_ZERO];
      flags_reg.ovfl   <= wb_dat_i[`DEX_ST_OVFL];
    end
  end

  // data memory, no reset: contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (state_reg == dex_pkg::DEX_Q4) begin
      if ((is_dec_reg || is_dsz_reg) && dest_reg) begin
        mem_reg[addr_reg] <= result_reg;
      end
    end else if (wr_ok && sel_lo && hit_mem) begin
      mem_reg[mem_idx] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // unmapped addresses answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `DEX_WORD_ZERO;
    end else if (req) begin
      wb_dat_o <= `DEX_WORD_ZERO;
      if (wb_adr_i == `DEX_ADR_INSTR) begin
        wb_dat_o[15:0] <= opc_reg;
      end else if (wb_adr_i == `DEX_ADR_WORK) begin
        wb_dat_o[7:0] <= work_reg;
      end else if (wb_adr_i == `DEX_ADR_STATUS) begin
        wb_dat_o[`DEX_ST_CARRY]  <= flags_reg.carry;
        wb_dat_o[`DEX_ST_DCARRY] <= flags_reg.dcarry;
        wb_dat_o[`DEX_ST_ZERO]   <= flags_reg.zero;
        wb_dat_o[`DEX_ST_OVFL]   <= flags_reg.ovfl;
        wb_dat_o[`DEX_ST_BUSY]   <= state_reg != dex_pkg::DEX_IDLE;
        wb_dat_o[`DEX_ST_SKIP]   <= skip_reg;
        wb_dat_o[`DEX_ST_OTHER]  <= other_reg;
      end else if (hit_mem) begin
        wb_dat_o[7:0] <= mem_reg[mem_idx];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      skip_o <= 1'b0;
    end else begin
      busy_o <= state_next != dex_pkg::DEX_IDLE;
      skip_o <= state_next == dex_pkg::DEX_N1 ||
                state_next == dex_pkg::DEX_N2 ||
                state_next == dex_pkg::DEX_N3 ||
                state_next == dex_pkg::DEX_N4;
    end
  end
endmodule

// File: include/dex_regs.svh
// Purpose: register offsets, field positions and opcode patterns
// Assumes: byte addresses on a 32-bit classic bus
// Notes:   definitions only
`ifndef DEX_REGS_SVH
`define DEX_REGS_SVH

`define DEX_ADR_INSTR     12'h000
`define DEX_ADR_WORK      12'h004
`define DEX_ADR_STATUS    12'h008
`define DEX_MEM_SEL       2'h1
`define DEX_ADR_HI        11
`define DEX_ADR_MID       10
`define DEX_ADR_WORD_HI   9
`define DEX_ADR_WORD_LO   2

`define DEX_ST_CARRY      0
`define DEX_ST_DCARRY     1
`define DEX_ST_ZERO       2
`define DEX_ST_OVFL       3
`define DEX_ST_BUSY       4
`define DEX_ST_SKIP       5
`define DEX_ST_OTHER      6

`define DEX_OP_DEC        7'h03
`define DEX_OP_DSZ        7'h0B
`define DEX_OP_HI         15
`define DEX_OP_LO         9
`define DEX_OP_DEST       8

`define DEX_BYTE_ONE      8'h01
`define DEX_BYTE_ZERO     8'h00
`define DEX_NIB_ZERO      4'h0
`define DEX_BYTE_OVFL     8'h80
`define DEX_OPC_RESET     16'h0000
`define DEX_WORD_ZERO     32'h0000_0000
`define DEX_MEM_DEPTH     256

`endif

// File: include/dex_pkg.sv
// Purpose: shared types of the decrement execution block
// Assumes: one-hot sequencer encoding
// Notes:   constants live in dex_regs.svh
package dex_pkg;

  typedef enum logic [8:0] {
    DEX_IDLE = 9'b0_0000_0001,
    DEX_Q1   = 9'b0_0000_0010,
    DEX_Q2   = 9'b0_0000_0100,
    DEX_Q3   = 9'b0_0000_1000,
    DEX_Q4   = 9'b0_0001_0000,
    DEX_N1   = 9'b0_0010_0000,
    DEX_N2   = 9'b0_0100_0000,
    DEX_N3   = 9'b0_1000_0000,
    DEX_N4   = 9'b1_0000_0000
  } dex_state_t;

  typedef struct packed {
    logic ovfl;
    logic zero;
    logic dcarry;
    logic carry;
  } dex_flags_t;

endpackage

// File: include/dex_alu_if.sv
// Purpose: carries opcode and operand to the decode unit and back
// Assumes: purely combinational decode side
// Notes:   core drives opcode and operand
`timescale 1ns/10ps
interface dex_alu_if;
  logic [15:0]         opcode;
  logic [7:0]          operand;
  logic                is_dec;
  logic                is_dsz;
  logic                dest;
  logic [7:0]          addr;
  logic [7:0]          result;
  dex_pkg::dex_flags_t flags;

  modport core (output opcode, output operand, input is_dec, input is_dsz,
                input dest, input addr, input result, input flags);
  modport alu  (input opcode, input operand, output is_dec, output is_dsz,
                output dest, output addr, output result, output flags);
endinterface

// File: rtl/dex_alu.sv
// Purpose: decodes the two decrement opcodes and forms result and flags
// Assumes: operand is the byte read from the addressed register
// Notes:   combinational only
`timescale 1ns/10ps
`include "dex_regs.svh"
module dex_alu (
  dex_alu_if.alu bus
);
  always_comb begin
    bus.is_dec = bus.opcode[`DEX_OP_HI:`DEX_OP_LO] == `DEX_OP_DEC;
    bus.is_dsz = bus.opcode[`DEX_OP_HI:`DEX_OP_LO] == `DEX_OP_DSZ;
    bus.dest   = bus.opcode[`DEX_OP_DEST];
    bus.addr   = bus.opcode[7:0];
    bus.result = bus.operand - `DEX_BYTE_ONE;
    // borrow only when the minuend field is zero
    bus.flags.carry  = bus.operand != `DEX_BYTE_ZERO;
    bus.flags.dcarry = bus.operand[3:0] != `DEX_NIB_ZERO;
    bus.flags.ovfl   = bus.operand == `DEX_BYTE_OVFL;
    bus.flags.zero   = bus.result == `DEX_BYTE_ZERO;
  end
endmodule

// File: tb/dex_exec_chk.sv
// Purpose: port-level assertions for the decrement execution block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the top module
`timescale 1ns/10ps
module dex_exec_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        busy_o,
  input wire logic        skip_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic go;
  // an opcode taken while idle; a busy write is refused, so no start
  assign go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !busy_o &&
              wb_adr_i == 12'h000 && wb_sel_i[0];
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_exec_four: assert property (
    go |=> busy_o [*4] ##1 (!busy_o || skip_o))
    else $error("execution not one four-phase cycle");
  a_skip_four: assert property ($rose(skip_o) |-> skip_o [*4] ##1 !skip_o)
    else $error("forced nop not four phases");
  a_skip_busy: assert property (skip_o |-> busy_o)
    else $error("skip without busy");
  a_skip_follow: assert property ($rose(skip_o) |-> $past(busy_o, 4))
    else $error("skip not after an executed cycle");
  a_work_byte: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 12'h004
    |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("working register wider than a byte");
  a_unmap_zero: assert property (
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 12'h00C
    |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule

bind dex_exec dex_exec_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .busy_o(busy_o), .skip_o(skip_o));

// File: tb/decrement_instruction_exec_tb_top.sv
// Purpose: random and corner tests of both decrement opcodes
// Assumes: classic single-cycle bus master, fixed seed
// Notes:   busy cycles are counted to see the forced nop
`timescale 1ns/10ps
module decrement_instruction_exec_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dato;
  logic [31:0] rd;
  logic        ack;
  logic        busy;
  logic        skip;
  int          err_total = 0;
  int          n_checks = 0;
  int          nb = 0;
  int          ns = 0;
  logic [3:0]  wsel = 4'h3;
  int          seed = 94;
  logic [7:0]  cv [4] = '{8'h01, 8'h00, 8'h80, 8'h10};
  always #10 clk_i = ~clk_i;
  dex_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .busy_o(busy),
    .skip_o(skip));
  always @(posedge clk_i) if (busy === 1'b1) nb <= nb + 1;
  always @(posedge clk_i) if (skip === 1'b1) ns <= ns + 1;
  // waits on ack with no cycle budget; only the watchdog ends a hang
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= wsel;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] exp_st(logic op, logic [7:0] v,
                                         logic [3:0] s);
    logic [7:0] r;
    r = v - 8'h01;
    if (op) return 32'({r == 8'h00, 1'b0, s});
    return 32'({v == 8'h80, r == 8'h00, v[3:0] != 4'h0, v != 8'h00});
  endfunction
  initial begin
    logic [7:0] v, f, w, r;
    logic [3:0] s;
    logic       op, d;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      v  = (i < 8) ? cv[i % 4] : 8'($random(seed));
      op = (i < 8) ? i[2] : 1'($random(seed));
      f  = 8'($random(seed));
      w  = 8'($random(seed));
      s  = 4'($random(seed));
      d  = 1'($random(seed));
      r  = v - 8'h01;
      wb(1'b1, {2'b01, f, 2'b00}, 32'(v));
      wb(1'b1, 12'h004, 32'(w));
      wb(1'b1, 12'h008, 32'(s));
      nb = 0;
      ns = 0;
      wb(1'b1, 12'h000, {16'h0000, op ? 7'h0B : 7'h03, d, f});
      do wb(1'b0, 12'h008, 32'h0000_0000); while (rd[4] !== 1'b0);
      chk("status", exp_st(op, v, s), rd);
      chk("cycles", (op && r == 8'h00) ? 8 : 4, nb);
      chk("skips", (op && r == 8'h00) ? 4 : 0, ns);
      wb(1'b0, {2'b01, f, 2'b00}, 32'h0000_0000);
      chk("mem", 32'(d ? r : v), rd);
      wb(1'b0, 12'h004, 32'h0000_0000);
      chk("work", 32'(d ? w : r), rd);
    end
    $display("test decrement done");
    // a foreign opcode runs as a nop; a write while busy is dropped
    wb(1'b1, 12'h004, 32'h0000_005A);
    wb(1'b1, 12'h008, 32'h0000_0009);
    nb = 0;
    wb(1'b1, 12'h000, 32'h0000_0800);
    wb(1'b1, 12'h004, 32'h0000_00A5);
    do wb(1'b0, 12'h008, 32'h0000_0000); while (rd[4] !== 1'b0);
    chk("other status", 32'h0000_0049, rd);
    chk("other cycles", 32'h0000_0004, nb);
    wb(1'b0, 12'h004, 32'h0000_0000);
    chk("busy write", 32'h0000_005A, rd);
    // upper opcode byte alone must not start execution
    wsel = 4'h2;
    nb = 0;
    wb(1'b1, 12'h000, 32'h0000_0700);
    wsel = 4'h3;
    wb(1'b0, 12'h000, 32'h0000_0000);
    chk("opcode", 32'h0000_0700, rd);
    chk("no start", 32'h0000_0000, nb);
    $display("test refuse done");
    wb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    wb(1'b0, 12'h00C, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    $display("test unmapped done");
    end_sim;
  end
  // forty opcodes need about 1000 cycles; this allows far more
  initial begin
    #1_000_000;
    err_total++;
    end_sim;
  end
endmodule
